// file: msc_pkg.sv
package msc_pkg;

  // ----------------------------------------
  // sync sources and option encodings
  // ----------------------------------------
  typedef enum logic [1:0] {
    MSC_SRC_EXT,
    MSC_SRC_INT,
    MSC_SRC_POD,
    MSC_SRC_FREE
  } msc_src_t;

  typedef enum logic [1:0] {
    MSC_EN_ALWAYS,
    MSC_EN_HIGH,
    MSC_EN_LOW,
    MSC_EN_POD
  } msc_en_mode_t;

  typedef enum logic {
    MSC_POD_ADDR,
    MSC_POD_DATA
  } msc_pod_mode_t;

  typedef enum logic {
    MSC_CNT_TRANS,
    MSC_CNT_FREQ
  } msc_cnt_mode_t;

  // ----------------------------------------
  // timing and field constants
  // ----------------------------------------
  localparam int  MSC_CLK_HZ       = 100_000_000;
  localparam int  MSC_FREE_HZ      = 1_000;
  localparam int  MSC_FREE_HALF    = MSC_CLK_HZ / (2 * MSC_FREE_HZ);
  localparam int  MSC_GATE_HZ      = 1;
  localparam int  MSC_GATE_CYCLES  = MSC_CLK_HZ / MSC_GATE_HZ;
  localparam int  MSC_STAT_DCLK    = 0;
  localparam int  MSC_STAT_ENA     = 1;
  localparam int  MSC_STAT_START   = 2;
  localparam int  MSC_STAT_STOP    = 3;
  localparam int  MSC_OVF_BIT      = 31;
  localparam logic [31:0] MSC_STAT_RST = 32'h0000_0000;
  localparam logic [31:0] MSC_CNT_RST  = 32'h0000_0000;

endpackage : msc_pkg

// file: msc_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none

module msc_edge_sync (
  input  wire  logic clk,
  input  wire  logic sys_rst,
  input  wire  logic pin,
  input  wire  logic pol_rise,
  output logic       level,
  output logic       edge_pulse
);

  // ----------------------------------------
  // two-flop synchroniser plus edge history
  // ----------------------------------------
  logic meta;
  logic sync;
  logic last;

  // meta is read only by sync; edge logic sees sync and last
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= pin;
      sync <= meta;
      last <= sync;
    end
  end

  assign level      = sync;
  assign edge_pulse = pol_rise ? (sync & ~last) : (~sync & last);

endmodule : msc_edge_sync

`default_nettype wire

// file: msc_sync_ctrl.sv
// Operation
// - start, stop, clock act on edges; enable acts on its level
// - external mode ignores clock edges until a start edge arrives
// - after start, sample on each active clock edge while enabled
// - end on stop edge or on reaching programmed enabled-edge count
// - probe pulse toggles once per enabled clock edge under external sync
// - free-running source is an internal oscillator near one kilohertz
// - four-way source select held separately per measuring device
// - internal mode samples on an explicit program strobe
// - internal mode also samples on each pattern-write step
// - pod makes one bus-cycle sync kind shared by all its users
// - pod supports address-phase and data-phase sync by separate command
// - unassigned external leads are treated as unused
// - status bits: stop, start, enable, clocked from bit 3 down to 0
// - falling edge of pod cycle sync marks the start of a bus access
// - counter overflow sets the top bit of the returned count
`timescale 1ns/1ps
`default_nettype none

module msc_sync_ctrl
  import msc_pkg::*;
#(
  parameter int STOP_W     = 16,
  parameter int FREE_HALF  = MSC_FREE_HALF,
  parameter int GATE_CYCLES = MSC_GATE_CYCLES
) (
  input  wire  logic              clk,
  input  wire  logic              sys_rst,
  input  wire  msc_src_t          sync_src,
  input  wire  msc_en_mode_t      enable_mode,
  input  wire  msc_cnt_mode_t     counter_mode,
  input  wire  msc_pod_mode_t     pod_mode_sel,
  input  wire  logic              start_rise,
  input  wire  logic              stop_rise,
  input  wire  logic              clock_rise,
  input  wire  logic              stop_by_count,
  input  wire  logic [STOP_W-1:0] stop_count,
  input  wire  logic              start_used,
  input  wire  logic              stop_used,
  input  wire  logic              clock_used,
  input  wire  logic              enable_used,
  input  wire  logic              arm,
  input  wire  logic              readout,
  input  wire  logic              strobe,
  input  wire  logic              patt_write,
  input  wire  logic              ext_start,
  input  wire  logic              ext_stop,
  input  wire  logic              ext_clock,
  input  wire  logic              ext_enable,
  input  wire  logic              pod_cycle_sync_n,
  input  wire  logic              pod_addr_phase,
  input  wire  logic              meas_pin,
  output logic                    sample,
  output logic                    pulse_out,
  output logic                    measuring,
  output logic [31:0]             status,
  output logic [31:0]             count_result,
  output msc_pod_mode_t           pod_mode
);

  // ----------------------------------------
  // pin synchronisers and edge detectors
  // ----------------------------------------
  logic start_edge, stop_edge, clk_edge, ena_lvl;
  logic pod_lvl, pod_fall, ap_lvl, mp_rise;

  msc_edge_sync u_start (.clk(clk), .sys_rst(sys_rst), .pin(ext_start),
                         .pol_rise(start_rise), .level(), .edge_pulse(start_edge));
  msc_edge_sync u_stop  (.clk(clk), .sys_rst(sys_rst), .pin(ext_stop),
                         .pol_rise(stop_rise), .level(), .edge_pulse(stop_edge));
  msc_edge_sync u_clock (.clk(clk), .sys_rst(sys_rst), .pin(ext_clock),
                         .pol_rise(clock_rise), .level(), .edge_pulse(clk_edge));
  msc_edge_sync u_ena   (.clk(clk), .sys_rst(sys_rst), .pin(ext_enable),
                         .pol_rise(1'b1), .level(ena_lvl), .edge_pulse());
  msc_edge_sync u_pod   (.clk(clk), .sys_rst(sys_rst), .pin(pod_cycle_sync_n),
                         .pol_rise(1'b0), .level(pod_lvl), .edge_pulse(pod_fall));
  msc_edge_sync u_ap    (.clk(clk), .sys_rst(sys_rst), .pin(pod_addr_phase),
                         .pol_rise(1'b1), .level(ap_lvl), .edge_pulse());
  msc_edge_sync u_mp    (.clk(clk), .sys_rst(sys_rst), .pin(meas_pin),
                         .pol_rise(1'b1), .level(), .edge_pulse(mp_rise));

  // ----------------------------------------
  // measurement window and external-sync state
  // ----------------------------------------
  typedef enum logic [1:0] {
    MSC_IDLE,
    MSC_WAIT_START,
    MSC_RUN,
    MSC_DONE
  } msc_state_t;

  msc_state_t        state, next_state;
  logic [STOP_W-1:0] edge_cnt, next_edge_cnt;
  logic [3:0]        flags, next_flags;
  logic              pulse, next_pulse;
  logic              smp, next_smp;
  logic              en_ok, en_clk, ext_stop_hit;
  logic              pod_match, src_tick;
  logic              free_tick;

  // one pod sync kind at a time; phase tag selects address or data cycles
  assign pod_mode  = pod_mode_sel;
  assign pod_match = pod_fall & ((pod_mode_sel == MSC_POD_ADDR) == ap_lvl);

  // enable qualifier; an unassigned enable lead counts as asserted
  always_comb begin
    case (enable_mode)
      MSC_EN_HIGH: en_ok = ~enable_used | ena_lvl;
      MSC_EN_LOW:  en_ok = ~enable_used | ~ena_lvl;
      MSC_EN_POD:  en_ok = ~pod_lvl;
      default:     en_ok = 1'b1;
    endcase
  end

  assign en_clk       = clock_used & clk_edge & en_ok;
  assign ext_stop_hit = stop_by_count ? (edge_cnt + STOP_W'(1) == stop_count) & en_clk
                                      : stop_used & stop_edge;

  // sample source for non-external modes
  always_comb begin
    case (sync_src)
      MSC_SRC_INT:  src_tick = strobe | patt_write;
      MSC_SRC_POD:  src_tick = pod_match;
      MSC_SRC_FREE: src_tick = free_tick;
      default:      src_tick = 1'b0;
    endcase
  end

  // next-state for the arm..readout window
  always_comb begin
    next_state    = state;
    next_edge_cnt = edge_cnt;
    next_flags    = flags;
    next_pulse    = pulse;
    next_smp      = 1'b0;
    if (arm) begin
      next_state    = (sync_src == MSC_SRC_EXT) ? MSC_WAIT_START : MSC_RUN;
      next_edge_cnt = '0;
      next_flags    = 4'h0;
    end else if (readout) begin
      next_state = MSC_IDLE;
    end else begin
      case (state)
        MSC_WAIT_START: begin
          // clock edges before start are dropped
          if (!start_used || start_edge) begin
            next_state                 = MSC_RUN;
            next_flags[MSC_STAT_START] = 1'b1;
          end
        end
        MSC_RUN: begin
          if (sync_src == MSC_SRC_EXT) begin
            if (en_ok && enable_used) next_flags[MSC_STAT_ENA] = 1'b1;
            if (en_clk) begin
              next_smp                  = 1'b1;
              next_pulse                = ~pulse;
              next_edge_cnt             = edge_cnt + STOP_W'(1);
              next_flags[MSC_STAT_DCLK] = 1'b1;
            end
            if (ext_stop_hit) begin
              next_state                = MSC_DONE;
              next_flags[MSC_STAT_STOP] = 1'b1;
            end
          end else if (src_tick) begin
            next_smp   = 1'b1;
            next_pulse = ~pulse;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state    <= MSC_IDLE;
      edge_cnt <= '0;
      flags    <= 4'h0;
      pulse    <= 1'b0;
      smp      <= 1'b0;
    end else begin
      state    <= next_state;
      edge_cnt <= next_edge_cnt;
      flags    <= next_flags;
      pulse    <= next_pulse;
      smp      <= next_smp;
    end
  end

  assign sample    = smp;
  assign pulse_out = pulse;
  assign measuring = (state == MSC_RUN) || (state == MSC_WAIT_START);
  assign status    = MSC_STAT_RST | {28'h000_0000, flags};

  // ----------------------------------------
  // free-running oscillator, about 1 kHz
  // ----------------------------------------
  logic [31:0] free_div, next_free_div;

  // runs always so the stimulus stays periodic across arm cycles
  always_comb begin
    next_free_div = (free_div == 32'(FREE_HALF - 1)) ? 32'h0000_0000 : free_div + 32'h0000_0001;
  end
  assign free_tick = (free_div == 32'(FREE_HALF - 1));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) free_div <= 32'h0000_0000;
    else         free_div <= next_free_div;
  end

  // ----------------------------------------
  // transition / frequency counter
  // ----------------------------------------
  logic [31:0] tcnt, next_tcnt;
  logic [31:0] gate, next_gate;
  logic [31:0] fres, next_fres;
  logic [31:0] res, next_res;
  logic        ovf, next_ovf;

  // freq: edges per one-second gate; overflow sticks in bit 31
  always_comb begin
    next_tcnt = tcnt;
    next_gate = gate;
    next_fres = fres;
    next_ovf  = ovf;
    next_res  = res;
    if (arm) begin
      next_tcnt = MSC_CNT_RST;
      next_gate = 32'h0000_0000;
      next_fres = MSC_CNT_RST;
      next_ovf  = 1'b0;
    end else if (measuring) begin
      if (mp_rise) begin
        if (tcnt[MSC_OVF_BIT-1:0] == 31'h7FFF_FFFF) next_ovf = 1'b1;
        next_tcnt = {1'b0, tcnt[MSC_OVF_BIT-1:0] + 31'h0000_0001};
      end
      if (counter_mode == MSC_CNT_FREQ) begin
        if (gate == 32'(GATE_CYCLES - 1)) begin
          next_gate = 32'h0000_0000;
          next_fres = next_tcnt;
          next_tcnt = MSC_CNT_RST;
        end else begin
          next_gate = gate + 32'h0000_0001;
        end
      end
    end
    if (readout) begin
      next_res = (counter_mode == MSC_CNT_FREQ) ? fres : tcnt;
      next_res[MSC_OVF_BIT] = next_ovf;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tcnt <= MSC_CNT_RST;
      gate <= 32'h0000_0000;
      fres <= MSC_CNT_RST;
      res  <= MSC_CNT_RST;
      ovf  <= 1'b0;
    end else begin
      tcnt <= next_tcnt;
      gate <= next_gate;
      fres <= next_fres;
      res  <= next_res;
      ovf  <= next_ovf;
    end
  end

  assign count_result = res;

endmodule : msc_sync_ctrl

`default_nettype wire

// file: msc_chk_properties.sv
`timescale 1ns/1ps
`default_nettype none
module msc_chk
  import msc_pkg::*;
(
  input wire logic          clk,
  input wire logic          sys_rst,
  input wire logic          arm,
  input wire logic          readout,
  input wire logic          strobe,
  input wire msc_src_t      sync_src,
  input wire msc_pod_mode_t pod_mode_sel,
  input wire logic          sample,
  input wire logic          pulse_out,
  input wire logic          measuring,
  input wire logic [31:0]   status,
  input wire logic [31:0]   count_result,
  input wire msc_pod_mode_t pod_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence s_int_strobe;
    sync_src == MSC_SRC_INT && measuring && strobe && !readout && !arm;
  endsequence
  sequence s_readout_only;
    readout && !arm;
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  AST_ARM_CLEARS: assert property (arm |=> status == MSC_STAT_RST && measuring)
    else $error("arm left flags set or not measuring");
  AST_INT_STROBE: assert property (s_int_strobe |=> sample)
    else $error("strobe gave no sample");
  AST_PULSE_TOGGLE: assert property (sample |-> pulse_out != $past(pulse_out))
    else $error("pulse output did not toggle");
  AST_SAMPLE_WINDOW: assert property (sample |-> $past(measuring))
    else $error("sample outside window");
  AST_STATUS_UPPER: assert property (status[31:4] == 28'h000_0000)
    else $error("status upper bits set");
  AST_POD_MODE: assert property (pod_mode == pod_mode_sel)
    else $error("pod sync kind mismatch");
  AST_READOUT_ENDS: assert property (s_readout_only |=> !measuring)
    else $error("still measuring after readout");
  AST_STOP_ENDS: assert property ($rose(status[MSC_STAT_STOP]) |-> !measuring)
    else $error("stop flag without end of window");
  AST_COUNT_HOLD: assert property (!$past(readout) && !$past(arm) |-> $stable(count_result))
    else $error("count changed without readout");
endmodule : msc_chk
`default_nettype wire

// file: msc_lead_model.sv
`timescale 1ns/1ps
`default_nettype none
module msc_lead_model (
  input  wire logic clk,
  output logic      ext_start,
  output logic      ext_stop,
  output logic      ext_clock,
  output logic      ext_enable,
  output logic      meas_pin
);
  // leads idle low; this lead model drives them all the time
  initial begin
    {ext_start, ext_stop, ext_clock, ext_enable, meas_pin} = 5'h0_0;
  end
  // one pulse: 0 start, 1 stop, 2 clock, 3 measured pin; 8 cycles keeps edges apart
  task automatic pulse(input int sel);
    @(negedge clk);
    case (sel)
      0: ext_start = 1'b1;
      1: ext_stop = 1'b1;
      2: ext_clock = 1'b1;
      default: meas_pin = 1'b1;
    endcase
    repeat (4) @(negedge clk);
    {ext_start, ext_stop, ext_clock, meas_pin} = 4'h0;
    repeat (4) @(negedge clk);
  endtask : pulse
  // enable lead is a level
  task automatic level(input logic v);
    @(negedge clk);
    ext_enable = v;
  endtask : level
endmodule : msc_lead_model
`default_nettype wire

// file: measurement_sync_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module measurement_sync_control_tb
  import msc_pkg::*;
;
  logic clk, sys_rst, start_rise, stop_rise, clock_rise, stop_by_count;
  logic start_used, stop_used, clock_used, enable_used, arm, readout, strobe, patt_write;
  logic pod_cycle_sync_n, pod_addr_phase, p0;
  logic [15:0] stop_count;
  msc_src_t sync_src;
  msc_en_mode_t enable_mode;
  msc_cnt_mode_t counter_mode;
  msc_pod_mode_t pod_mode_sel, pod_mode;
  wire logic ext_start, ext_stop, ext_clock, ext_enable, meas_pin;
  logic sample, pulse_out, measuring;
  logic [31:0] status, count_result;
  int bad_count, samples_checked, n_samp, cycles;

  msc_sync_ctrl #(.STOP_W(16), .FREE_HALF(5), .GATE_CYCLES(100)) dut (
    .clk, .sys_rst, .sync_src, .enable_mode, .counter_mode, .pod_mode_sel, .start_rise,
    .stop_rise, .clock_rise, .stop_by_count, .stop_count, .start_used, .stop_used,
    .clock_used, .enable_used, .arm, .readout, .strobe, .patt_write, .ext_start, .ext_stop,
    .ext_clock, .ext_enable, .pod_cycle_sync_n, .pod_addr_phase, .meas_pin, .sample,
    .pulse_out, .measuring, .status, .count_result, .pod_mode);
  msc_lead_model lead (.clk, .ext_start, .ext_stop, .ext_clock, .ext_enable, .meas_pin);

  // clock, sample tally and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (sample === 1'b1) n_samp <= n_samp + 1;
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      conclude();
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  // one-cycle command: 0 arm, 1 readout, 2 strobe, 3 pattern write
  task automatic cmd(input int sel);
    @(negedge clk);
    {arm, readout, strobe, patt_write} = 4'b1000 >> sel;
    @(negedge clk);
    {arm, readout, strobe, patt_write} = 4'h0;
    repeat (4) @(negedge clk);
  endtask : cmd
  task automatic conclude();
    if (bad_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {sys_rst, start_rise, stop_rise, clock_rise, pod_cycle_sync_n} = 5'h1F;
    {stop_by_count, arm, readout, strobe, patt_write, pod_addr_phase} = 6'h00;
    {start_used, stop_used, clock_used, enable_used} = 4'hF;
    {bad_count, samples_checked, n_samp, cycles} = '0;
    stop_count = 16'h0003;
    sync_src = MSC_SRC_EXT;
    enable_mode = MSC_EN_HIGH;
    counter_mode = MSC_CNT_TRANS;
    pod_mode_sel = MSC_POD_ADDR;
    repeat (6) @(posedge clk);
    @(negedge clk) sys_rst = 1'b0;
    check(status, 32'h0000_0000);
    check({29'h0, sample, pulse_out, measuring}, 32'h0000_0000);
    // external sync, stop by edge
    cmd(0);
    n_samp = 0;
    p0 = pulse_out;
    repeat (2) lead.pulse(2);
    check(n_samp, 0);
    lead.pulse(0);
    lead.level(1'b1);
    repeat (3) lead.pulse(2);
    lead.level(1'b0);
    repeat (2) lead.pulse(2);
    check(n_samp, 3);
    check({31'h0, pulse_out}, {31'h0, ~p0});
    check(status, 32'h0000_0007);
    lead.pulse(1);
    lead.pulse(2);
    check(status, 32'h0000_000F);
    check({31'h0, measuring}, 32'h0000_0000);
    check(n_samp, 3);
    cmd(1);
    // stop by count, start lead unused, falling clock edges, enabled while pod sync low
    {stop_by_count, start_used, clock_rise} = 3'b100;
    stop_count = 16'h0004;
    enable_mode = MSC_EN_POD;
    cmd(0);
    n_samp = 0;
    lead.pulse(2);
    pod_cycle_sync_n = 1'b0;
    repeat (5) lead.pulse(2);
    pod_cycle_sync_n = 1'b1;
    check(n_samp, 4);
    check({31'h0, measuring}, 32'h0000_0000);
    cmd(1);
    // clock, stop and enable leads unassigned: no samples, no stop, no enable flag
    {clock_used, stop_by_count, stop_used, enable_used} = 4'b0000;
    enable_mode = MSC_EN_HIGH;
    cmd(0);
    n_samp = 0;
    repeat (2) lead.pulse(2);
    lead.pulse(1);
    check(n_samp, 0);
    check(status, 32'h0000_0004);
    check({31'h0, measuring}, 32'h0000_0001);
    cmd(1);
    // falling start and stop edges, clock gated by an active-low enable lead
    {clock_used, stop_by_count, start_used, start_rise, stop_rise} = 5'b10100;
    {stop_used, enable_used} = 2'b11;
    enable_mode = MSC_EN_LOW;
    cmd(0);
    n_samp = 0;
    lead.pulse(0);
    lead.pulse(2);
    lead.level(1'b1);
    lead.pulse(2);
    lead.level(1'b0);
    lead.pulse(1);
    lead.pulse(2);
    check(n_samp, 1);
    check(status, 32'h0000_000F);
    cmd(1);
    // internal sync: strobes and pattern writes
    sync_src = MSC_SRC_INT;
    cmd(0);
    n_samp = 0;
    cmd(2);
    cmd(2);
    cmd(3);
    check(n_samp, 3);
    cmd(1);
    cmd(2);
    check(n_samp, 3);
    // pod sync, data phase then address phase; the middle cycle is an address cycle
    sync_src = MSC_SRC_POD;
    for (int m = 0; m < 2; m++) begin
      pod_mode_sel = msc_pod_mode_t'(1 - m);
      cmd(0);
      n_samp = 0;
      for (int i = 0; i < 3; i++) begin
        pod_addr_phase = (i == 1);
        repeat (4) @(negedge clk);
        pod_cycle_sync_n = 1'b0;
        repeat (4) @(negedge clk);
        pod_cycle_sync_n = 1'b1;
      end
      repeat (4) @(negedge clk);
      check(n_samp, (m == 0) ? 2 : 1);
      check({31'h0, pod_mode}, {31'h0, pod_mode_sel});
      cmd(1);
    end
    // transition count then frequency over a 100-cycle gate
    cmd(0);
    repeat (5) lead.pulse(3);
    cmd(1);
    check(count_result, 32'h0000_0005);
    counter_mode = MSC_CNT_FREQ;
    cmd(0);
    repeat (30) lead.pulse(3);
    cmd(1);
    check(count_result, 32'h0000_000B);
    // free-running stimulus only, period 5 cycles
    sync_src = MSC_SRC_FREE;
    cmd(0);
    n_samp = 0;
    repeat (100) @(negedge clk);
    check(n_samp, 20);
    cmd(1);
    conclude();
  end
endmodule : measurement_sync_control_tb

bind msc_sync_ctrl msc_chk u_chk (.clk(clk), .sys_rst(sys_rst), .arm(arm),
  .readout(readout), .strobe(strobe), .sync_src(sync_src), .pod_mode_sel(pod_mode_sel),
  .sample(sample), .pulse_out(pulse_out), .measuring(measuring), .status(status),
  .count_result(count_result), .pod_mode(pod_mode));
`default_nettype wire
